// ===== charger_pkg.sv
// constants, carriers and state for the charge-cycle supervisor
package charger_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam longint CLK_HZ = 10_000_000;
    localparam longint UNATTENDED_MIN = 15;
    localparam longint WATCHDOG_S = 32;
    localparam longint CONNECT_MS = 256;
    localparam longint VALID_MS = 32;
    localparam logic [33:0] UNATTENDED_CYCLES = 34'(UNATTENDED_MIN * 60 * CLK_HZ);
    localparam logic [28:0] WATCHDOG_CYCLES = 29'(WATCHDOG_S * CLK_HZ);
    localparam logic [21:0] CONNECT_CYCLES = 22'(CONNECT_MS * CLK_HZ / 1000);
    localparam logic [21:0] VALID_CYCLES = 22'(VALID_MS * CLK_HZ / 1000);

    ////////////////////////////////////////////////////////////////////////////
    // register map: index and byte address
    localparam logic [7:0] REG0_IDX = 8'h00;
    localparam logic [7:0] REG1_IDX = 8'h01;
    localparam logic [7:0] REG2_IDX = 8'h02;
    localparam logic [7:0] REG4_IDX = 8'h04;
    localparam logic [7:0] REG7_IDX = 8'h07;
    localparam logic [7:0] REG0_ADDR = 8'(REG0_IDX * 4);
    localparam logic [7:0] REG1_ADDR = 8'(REG1_IDX * 4);
    localparam logic [7:0] REG2_ADDR = 8'(REG2_IDX * 4);
    localparam logic [7:0] REG4_ADDR = 8'(REG4_IDX * 4);
    localparam logic [7:0] REG7_ADDR = 8'(REG7_IDX * 4);

    // field positions
    localparam int KICK_BIT = 7;
    localparam int CONN_BIT = 6;
    localparam int TE_BIT = 3;
    localparam int CDIS_BIT = 2;
    localparam int HZ_BIT = 1;
    localparam int OVR_BIT = 7;
    localparam int PCEN_BIT = 3;
    localparam int PCON_BIT = 4;

    // reset values and write masks
    localparam logic [7:0] REG1_RST = 8'h48;
    localparam logic [7:0] REG2_RST = 8'h08;
    localparam logic [7:0] REG4_RST = 8'h80;
    localparam logic [7:0] REG7_RST = 8'h00;
    localparam logic [7:0] REG1_MASK = 8'hFE;
    localparam logic [7:0] REG2_MASK = 8'hFC;
    localparam logic [7:0] REG7_MASK = 8'h0F;

    // codes
    localparam logic [2:0] FAULT_NONE = 3'h0;
    localparam logic [2:0] FAULT_TIMER = 3'h6;
    localparam logic [1:0] STAT_READY = 2'h0;
    localparam logic [1:0] STAT_CHARGE = 2'h1;
    localparam logic [1:0] STAT_DONE = 2'h2;
    localparam logic [1:0] STAT_FAULT = 2'h3;
    localparam logic [5:0] FV_CAP_CODE = 6'h2F;
    localparam logic [3:0] ICHG_CAP_CODE = 4'hA;

    // analog levels in mV / mA
    localparam logic [12:0] FV_BASE_MV = 13'h0DAC;
    localparam logic [12:0] FV_STEP_MV = 13'h0014;
    localparam logic [10:0] ICHG_BASE_MA = 11'h226;
    localparam logic [10:0] ICHG_STEP_MA = 11'h064;
    localparam logic [10:0] ICHG_LOW_MA = 11'h154;
    localparam logic [10:0] SHORT_BATTERY_CURRENT_LOW_MA = 11'h00D;
    localparam logic [10:0] SHORT_BATTERY_CURRENT_HIGH_MA = 11'h01E;
    localparam logic [8:0] TERMINATION_CURRENT_CODE_STEP_MA = 9'h032;
    localparam logic [12:0] SYS_PP_MV = 13'h0DD4;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        ST_OFF, ST_CONNECT, ST_IDLE, ST_VALIDATE, ST_CHARGE, ST_TOPOFF, ST_DONE, ST_FAULT
    } charge_state_e;

    // comparator levels coming from the analog side
    typedef struct packed {
        logic input_present;
        logic input_in_range;
        logic below_recharge;
        logic below_weak;
        logic below_3v0;
        logic below_pp_exit;
        logic below_short;
        logic below_term;
        logic disable_pin;
    } sense_s;

    // decoded analog targets
    typedef struct packed {
        logic [12:0] float_voltage_mv;
        logic [10:0] charge_current_ma;
        logic [8:0] termination_current_ma;
    } target_s;

    typedef struct packed {
        sense_s sync1;
        sense_s sync2;
        charge_state_e st;
        logic [7:0] reg1;
        logic [7:0] reg2;
        logic [7:0] reg4;
        logic [7:0] reg7;
        logic [2:0] fault;
        logic conn_flag;
        logic topoff_active;
        logic rail_on;
        logic stat_pulse;
        logic ctrl_prev_cdis;
        logic ctrl_prev_hz;
        logic good_n_prev;
        logic unattended_run;
        logic watchdog_run;
        logic [33:0] unattended_cnt;
        logic [28:0] watchdog_cnt;
        logic [21:0] phase_cnt;
        logic [31:0] prdata;
        logic pslverr;
        target_s tgt;
    } state_s;

endpackage

// ===== charger_cycle_supervisor.sv
// charge-cycle supervisor with apb register slave
`timescale 1ns/1ps
module charger_cycle_supervisor #(
    parameter bit AUTO_CHARGE = 1'b1,
    parameter logic [33:0] UNATTENDED_CYCLES = charger_pkg::UNATTENDED_CYCLES,
    parameter logic [28:0] WATCHDOG_CYCLES = charger_pkg::WATCHDOG_CYCLES,
    parameter logic [21:0] CONNECT_CYCLES = charger_pkg::CONNECT_CYCLES,
    parameter logic [21:0] VALID_CYCLES = charger_pkg::VALID_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // analog comparators, asynchronous
    input wire charger_pkg::sense_s sense_i,
    // analog targets and switches
    output charger_pkg::target_s target_o,
    output logic charger_on_o,
    output logic input_load_o,
    output logic system_rail_on_o,
    output logic battery_switch_on_o,
    output logic bypass_switch_on_o,
    output logic power_path_mode_o,
    output logic [12:0] sys_reg_mv_o,
    output logic status_pin_o,
    output logic battery_good_n_o
);

    charger_pkg::state_s q;
    charger_pkg::state_s d;
    charger_pkg::sense_s s;
    logic enabled;
    logic acc;
    logic wr;
    logic any_wr;
    logic addr_ok;
    logic kick;
    logic good_n;
    logic pp_mode;
    logic start_charge;
    logic [5:0] fv_code;
    logic [3:0] ic_code;
    logic [2:0] term_code;

    ////////////////////////////////////////////////////////////////////////////
    // shared decodes
    assign s = q.sync2;
    assign acc = psel_i & penable_i;
    assign any_wr = acc & pwrite_i;
    assign enabled = ~s.disable_pin & ~q.reg1[charger_pkg::CDIS_BIT] & ~q.reg1[charger_pkg::HZ_BIT];
    assign pp_mode = (q.st == charger_pkg::ST_CHARGE) & s.below_pp_exit;
    // battery good stays high in power path or below the weak level
    assign good_n = pp_mode | s.below_weak;

    // address decode, unmapped answers with an error
    always_comb begin
        case (paddr_i)
            charger_pkg::REG0_ADDR, charger_pkg::REG1_ADDR, charger_pkg::REG2_ADDR,
            charger_pkg::REG4_ADDR, charger_pkg::REG7_ADDR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign wr = any_wr & addr_ok;
    assign kick = wr && paddr_i == charger_pkg::REG0_ADDR && pwdata_i[charger_pkg::KICK_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        d = q;
        start_charge = 1'b0;
        fv_code = 6'h00;
        ic_code = 4'h0;
        term_code = 3'h0;
        // two-stage synchroniser for comparator levels
        d.sync1 = sense_i;
        d.sync2 = q.sync1;
        d.stat_pulse = 1'b0;
        d.good_n_prev = good_n;
        d.ctrl_prev_cdis = q.reg1[charger_pkg::CDIS_BIT];
        d.ctrl_prev_hz = q.reg1[charger_pkg::HZ_BIT];

        // read data captured in the setup cycle
        if (psel_i && !penable_i) begin
            d.pslverr = ~addr_ok;
            case (paddr_i)
                charger_pkg::REG0_ADDR: d.prdata = {24'h0000_00, 1'b0, q.conn_flag,
                    (q.st == charger_pkg::ST_FAULT) ? charger_pkg::STAT_FAULT :
                    (q.st == charger_pkg::ST_CHARGE || q.st == charger_pkg::ST_VALIDATE) ?
                    charger_pkg::STAT_CHARGE :
                    (q.st == charger_pkg::ST_DONE || q.st == charger_pkg::ST_TOPOFF) ?
                    charger_pkg::STAT_DONE : charger_pkg::STAT_READY, 1'b0, q.fault};
                charger_pkg::REG1_ADDR: d.prdata = {24'h0000_00, q.reg1};
                charger_pkg::REG2_ADDR: d.prdata = {24'h0000_00, q.reg2};
                charger_pkg::REG4_ADDR: d.prdata = {24'h0000_00, q.reg4};
                charger_pkg::REG7_ADDR: d.prdata = {24'h0000_00, 3'b000, q.topoff_active, q.reg7[3:0]};
                default: d.prdata = 32'h0000_0000;
            endcase
        end

        // register writes
        if (wr) begin
            case (paddr_i)
                charger_pkg::REG1_ADDR: d.reg1 = pwdata_i[7:0] & charger_pkg::REG1_MASK;
                charger_pkg::REG2_ADDR: d.reg2 = pwdata_i[7:0] & charger_pkg::REG2_MASK;
                charger_pkg::REG4_ADDR: d.reg4 = pwdata_i[7:0];
                charger_pkg::REG7_ADDR: d.reg7 = pwdata_i[7:0] & charger_pkg::REG7_MASK;
                default: d.reg1 = q.reg1;
            endcase
        end

        // timers run by counting system clock cycles
        // cycle counting
        if (q.unattended_run) begin
            d.unattended_cnt = q.unattended_cnt + 34'h0_0000_0001;
        end
        if (q.watchdog_run) begin
            d.watchdog_cnt = q.watchdog_cnt + 29'h0000_0001;
        end

        // host write: unattended timer stops and clears, watchdog starts
        // write restarts supervision
        if (any_wr) begin
            d.unattended_run = 1'b0;
            d.unattended_cnt = 34'h0_0000_0000;
            d.watchdog_run = 1'b1;
            d.watchdog_cnt = 29'h0000_0000;
        end
        if (kick) begin
            d.watchdog_cnt = 29'h0000_0000;
        end

        // state machine
        case (q.st)
            charger_pkg::ST_OFF: begin
                d.phase_cnt = 22'h00_0000;
                if (s.input_present) begin
                    d.st = charger_pkg::ST_CONNECT;
                end
            end
            charger_pkg::ST_CONNECT: begin
                d.phase_cnt = q.phase_cnt + 22'h00_0001;
                if (q.phase_cnt >= CONNECT_CYCLES - 22'h00_0001) begin
                    d.conn_flag = 1'b1;
                    d.stat_pulse = 1'b1;
                    d.st = charger_pkg::ST_IDLE;
                    if (s.below_weak && !q.watchdog_run) begin
                        d.reg1 = charger_pkg::REG1_RST;
                        d.reg2 = charger_pkg::REG2_RST;
                        d.reg4 = charger_pkg::REG4_RST;
                        d.reg7 = charger_pkg::REG7_RST;
                        d.rail_on = 1'b1;
                    end
                    if (AUTO_CHARGE && s.below_weak && enabled) begin
                        start_charge = 1'b1;
                    end
                end
            end
            charger_pkg::ST_IDLE: begin
                if (any_wr && enabled) begin
                    start_charge = 1'b1;
                end
            end
            charger_pkg::ST_VALIDATE: begin
                if (!s.input_in_range) begin
                    d.phase_cnt = 22'h00_0000;
                end else if (q.phase_cnt >= VALID_CYCLES - 22'h00_0001) begin
                    d.st = charger_pkg::ST_CHARGE;
                    d.rail_on = 1'b1;
                    d.fault = charger_pkg::FAULT_NONE;
                    if (!d.watchdog_run) begin
                        d.unattended_run = 1'b1;
                        d.unattended_cnt = 34'h0_0000_0000;
                    end
                end else begin
                    d.phase_cnt = q.phase_cnt + 22'h00_0001;
                end
                if (!enabled) begin
                    d.st = charger_pkg::ST_IDLE;
                end
            end
            charger_pkg::ST_CHARGE: begin
                if (q.reg1[charger_pkg::TE_BIT] && s.below_term) begin
                    if (q.reg7[charger_pkg::PCEN_BIT]) begin
                        d.st = charger_pkg::ST_TOPOFF;
                        d.topoff_active = 1'b1;
                    end else begin
                        d.st = charger_pkg::ST_DONE;
                    end
                end
                if (any_wr && enabled) begin
                    start_charge = 1'b1;
                end
                if (!enabled) begin
                    d.st = charger_pkg::ST_IDLE;
                end
            end
            charger_pkg::ST_TOPOFF: begin
                if (s.below_term) begin
                    d.st = charger_pkg::ST_DONE;
                    d.topoff_active = 1'b0;
                end
                if ((good_n && !q.good_n_prev && s.below_3v0) ||
                    q.reg1[charger_pkg::CDIS_BIT] != q.ctrl_prev_cdis ||
                    q.reg1[charger_pkg::HZ_BIT] != q.ctrl_prev_hz) begin
                    d.st = charger_pkg::ST_IDLE;
                    d.topoff_active = 1'b0;
                end
            end
            charger_pkg::ST_DONE: begin
                if (enabled && (s.below_recharge || any_wr)) begin
                    start_charge = 1'b1;
                end
            end
            charger_pkg::ST_FAULT: begin
                if (any_wr && enabled) begin
                    start_charge = 1'b1;
                end
            end
            default: d.st = charger_pkg::ST_OFF;
        endcase

        if (q.unattended_run && q.unattended_cnt >= UNATTENDED_CYCLES - 34'h0_0000_0001 && !any_wr) begin
            d.unattended_run = 1'b0;
            d.fault = charger_pkg::FAULT_TIMER;
            d.topoff_active = 1'b0;
            d.st = charger_pkg::ST_FAULT;
        end

        if (q.watchdog_run && q.watchdog_cnt >= WATCHDOG_CYCLES - 29'h0000_0001 && !any_wr) begin
            d.watchdog_run = 1'b0;
            d.watchdog_cnt = 29'h0000_0000;
            d.reg1 = charger_pkg::REG1_RST;
            d.reg2 = charger_pkg::REG2_RST;
            d.reg4 = charger_pkg::REG4_RST;
            d.reg7 = charger_pkg::REG7_RST;
            d.fault = charger_pkg::FAULT_TIMER;
            d.stat_pulse = 1'b1;
            d.topoff_active = 1'b0;
            if (q.st != charger_pkg::ST_OFF && q.st != charger_pkg::ST_CONNECT) begin
                start_charge = 1'b1;
            end
        end

        if (start_charge) begin
            d.st = charger_pkg::ST_VALIDATE;
            d.phase_cnt = 22'h00_0000;
            d.topoff_active = 1'b0;
        end

        // input removal: power-on reset of the cycle
        if (!s.input_present) begin
            d.st = charger_pkg::ST_OFF;
            d.conn_flag = 1'b0;
            d.topoff_active = 1'b0;
            d.rail_on = 1'b0;
            d.unattended_run = 1'b0;
        end

        fv_code = (q.reg2[7:2] > charger_pkg::FV_CAP_CODE) ? charger_pkg::FV_CAP_CODE : q.reg2[7:2];
        d.tgt.float_voltage_mv = charger_pkg::FV_BASE_MV + 13'(fv_code) * charger_pkg::FV_STEP_MV;
        ic_code = (q.reg4[6:3] > charger_pkg::ICHG_CAP_CODE) ? charger_pkg::ICHG_CAP_CODE : q.reg4[6:3];
        d.tgt.charge_current_ma = charger_pkg::ICHG_BASE_MA + 11'(ic_code) * charger_pkg::ICHG_STEP_MA;
        if (q.reg4[charger_pkg::OVR_BIT] || pp_mode) begin
            d.tgt.charge_current_ma = charger_pkg::ICHG_LOW_MA;
        end
        if (s.below_short) begin
            d.tgt.charge_current_ma = (q.reg1[7:6] <= 2'b01) ? charger_pkg::SHORT_BATTERY_CURRENT_LOW_MA :
                                      charger_pkg::SHORT_BATTERY_CURRENT_HIGH_MA;
        end
        term_code = (q.st == charger_pkg::ST_TOPOFF) ? q.reg7[2:0] : q.reg4[2:0];
        d.tgt.termination_current_ma = (9'(term_code) + 9'h001) * charger_pkg::TERMINATION_CURRENT_CODE_STEP_MA;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register, frozen while clock enable is low and reset is released
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= charger_pkg::ST_OFF;
            q.reg1 <= charger_pkg::REG1_RST;
            q.reg2 <= charger_pkg::REG2_RST;
            q.reg4 <= charger_pkg::REG4_RST;
            q.reg7 <= charger_pkg::REG7_RST;
            q.ctrl_prev_cdis <= charger_pkg::REG1_RST[charger_pkg::CDIS_BIT];
            q.ctrl_prev_hz <= charger_pkg::REG1_RST[charger_pkg::HZ_BIT];
        end else if (ce_i) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata_o = q.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = acc & q.pslverr;
    assign target_o = q.tgt;
    assign charger_on_o = q.st == charger_pkg::ST_CHARGE || q.st == charger_pkg::ST_TOPOFF;
    assign input_load_o = q.st == charger_pkg::ST_VALIDATE;
    assign system_rail_on_o = q.rail_on;
    // both switches on while idle or off
    assign battery_switch_on_o = q.st == charger_pkg::ST_IDLE || q.st == charger_pkg::ST_OFF;
    assign bypass_switch_on_o = q.st == charger_pkg::ST_IDLE || q.st == charger_pkg::ST_OFF;
    assign power_path_mode_o = pp_mode;
    assign sys_reg_mv_o = pp_mode ? charger_pkg::SYS_PP_MV : q.tgt.float_voltage_mv;
    assign battery_good_n_o = good_n;
    // status high when done or top-off
    assign status_pin_o = q.st == charger_pkg::ST_DONE || q.st == charger_pkg::ST_TOPOFF || q.stat_pulse;

endmodule // charger_cycle_supervisor

// ===== charger_chk.sv
// port assertions for the charge-cycle supervisor
`timescale 1ns/1ps
module charger_chk #(
    parameter logic [21:0] VALID_CYCLES = 22'h00_000A
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [7:0] paddr_i,
    input wire logic pslverr_o,
    input wire charger_pkg::target_s target_o,
    input wire logic charger_on_o,
    input wire logic input_load_o,
    input wire logic battery_switch_on_o,
    input wire logic power_path_mode_o,
    input wire logic [12:0] sys_reg_mv_o,
    input wire logic battery_good_n_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire [12:0] fv = target_o.float_voltage_mv;
    wire [10:0] ic = target_o.charge_current_ma;
    wire [8:0] it = target_o.termination_current_ma;
    logic [21:0] load_q;
    // run length of the validation load
    always_ff @(posedge clk_sys_i) begin
        load_q <= (rst_i || !input_load_o) ? 22'h00_0000 : load_q + 22'h00_0001;
    end
    a_fv_grid: assert property (fv == 0 || (fv >= 13'h0DAC && fv <= 13'h1158 && (fv - 13'h0DAC) % 20 == 0))
        else $error("float target off grid");
    a_ichg_grid: assert property (ic inside {11'h000, 11'h00D, 11'h01E, 11'h154}
        || (ic >= 11'h226 && ic <= 11'h60E && (ic - 11'h226) % 100 == 0)) else $error("charge current off grid");
    a_term_grid: assert property (it <= 9'h190 && it % 50 == 0)
        else $error("termination current off grid");
    a_pp_rail: assert property (power_path_mode_o |-> sys_reg_mv_o == 13'h0DD4 && battery_good_n_o)
        else $error("power path rail wrong");
    a_pp_charge: assert property ($rose(power_path_mode_o) |-> charger_on_o)
        else $error("power path without charging");
    a_switch_idle: assert property (battery_switch_on_o |-> !charger_on_o && !input_load_o)
        else $error("switches on while active");
    a_load_excl: assert property (input_load_o |-> !charger_on_o)
        else $error("load and charger together");
    a_valid_span: assert property ($rose(charger_on_o) |-> $past(input_load_o) && load_q >= VALID_CYCLES - 1)
        else $error("charging before validation");
    a_bus_err: assert property (psel_i && penable_i |-> pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08,
        8'h10, 8'h1C})) else $error("bus error flag wrong");
endmodule // charger_chk

bind charger_cycle_supervisor charger_chk #(.VALID_CYCLES(VALID_CYCLES)) u_chk (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pslverr_o(pslverr_o),
    .target_o(target_o), .charger_on_o(charger_on_o), .input_load_o(input_load_o),
    .battery_switch_on_o(battery_switch_on_o), .power_path_mode_o(power_path_mode_o),
    .sys_reg_mv_o(sys_reg_mv_o), .battery_good_n_o(battery_good_n_o));

// ===== host_model.sv
// apb host model issuing one transfer per request
`timescale 1ns/1ps
module host_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] data_i,
    input wire logic pready_i,
    input wire logic [31:0] prdata_i,
    output logic psel_o = 1'b0,
    output logic penable_o = 1'b0,
    output logic pwrite_o = 1'b0,
    output logic [7:0] paddr_o = 8'h00,
    output logic [31:0] pwdata_o = 32'h0000_0000,
    output logic done_o = 1'b0,
    output logic [31:0] rdata_o = 32'h0000_0000
);
    // setup, access held until pready, then release
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (psel_o && penable_o && pready_i) begin
            rdata_o <= prdata_i;
            done_o <= 1'b1;
            psel_o <= 1'b0;
            penable_o <= 1'b0;
        end else if (psel_o) begin
            penable_o <= 1'b1;
        end else if (go_i && !done_o) begin
            psel_o <= 1'b1;
            pwrite_o <= wr_i;
            paddr_o <= addr_i;
            pwdata_o <= data_i;
        end
    end
endmodule // host_model

// ===== charger_cycle_supervisor_bench.sv
// self-checking bench for the charge-cycle supervisor
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module charger_cycle_supervisor_bench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic go = 1'b0, wr = 1'b0, done, psel, penable, pwrite, pready, pslverr;
    logic chg, load, rail, bsw, qsw, pp, stat, good_n;
    logic [7:0] addr = 8'h00, paddr;
    logic [12:0] sysmv;
    logic [31:0] wdata = 32'h0000_0000, pwdata, prdata, rdata, r;
    charger_pkg::sense_s sense = '0;
    charger_pkg::target_s tgt;
    int mismatches = 0, total_checks = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    host_model host (.clk_i(clk_sys_i), .go_i(go), .wr_i(wr), .addr_i(addr), .data_i(wdata), .pready_i(pready),
        .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .done_o(done), .rdata_o(rdata));
    charger_cycle_supervisor #(.UNATTENDED_CYCLES(34'h0_0000_0190), .WATCHDOG_CYCLES(29'h000_00C8),
        .CONNECT_CYCLES(22'h00_0014), .VALID_CYCLES(22'h00_000A)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .ce_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sense_i(sense), .target_o(tgt),
        .charger_on_o(chg), .input_load_o(load), .system_rail_on_o(rail), .battery_switch_on_o(bsw),
        .bypass_switch_on_o(qsw), .power_path_mode_o(pp), .sys_reg_mv_o(sysmv), .status_pin_o(stat),
        .battery_good_n_o(good_n));
    ////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys_i) {go, wr, addr, wdata} <= {1'b1, w, a, d};
        do @(negedge clk_sys_i); while (!done && ++n < 20);
        if (!done) mismatches++;
        r = rdata;
        @(posedge clk_sys_i) go <= 1'b0;
    endtask
    task automatic wait_v(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++) @(negedge clk_sys_i);
        if (s !== v) mismatches++;
    endtask
    task automatic do_reset(input logic [8:0] s);
        @(posedge clk_sys_i) {rst_i, sense} <= {1'b1, 9'h000};
        repeat (8) @(posedge clk_sys_i);
        {rst_i, sense} <= {1'b0, s};
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_decode();
        logic [5:0] fv[5] = '{6'h00, 6'h01, 6'h2E, 6'h2F, 6'h3F};
        do_reset(9'h000);
        tick(2);
        `CHK(tgt.charge_current_ma, 11'h154)
        `CHK(tgt.float_voltage_mv, 13'h0DD4)
        bus(0, 8'h0C, 32'h0000_0000);
        `CHK(r, 32'h0000_0000)
        foreach (fv[i]) begin
            bus(1, charger_pkg::REG2_ADDR, {24'h00_0000, fv[i], 2'b00});
            tick(2);
            `CHK(tgt.float_voltage_mv, 13'(3500 + 20 * (fv[i] > 6'h2F ? 47 : int'(fv[i]))))
        end
        for (int c = 0; c < 16; c += 5) begin
            bus(1, charger_pkg::REG4_ADDR, 32'(c * 8 + c % 8));
            tick(2);
            `CHK(tgt.charge_current_ma, 11'(550 + 100 * (c > 10 ? 10 : c)))
            `CHK(tgt.termination_current_ma, 9'(50 * (c % 8 + 1)))
        end
        bus(1, charger_pkg::REG4_ADDR, 32'h0000_00FF);
        tick(2);
        `CHK(tgt.charge_current_ma, 11'h154)
        $display("test decode done");
    endtask
    task automatic t_charge();
        do_reset(9'h1AC); // weak, power path, short battery
        wait_v(stat, 1'b1, 40);
        bus(0, charger_pkg::REG0_ADDR, 32'h0000_0000);
        `CHK(r[6], 1'b1)
        `CHK(rail, 1'b1)
        wait_v(chg, 1'b1, 40);
        `CHK(chg, 1'b1)
        tick(3);
        `CHK({pp, good_n, sysmv}, {2'b11, 13'h0DD4})
        `CHK(tgt.charge_current_ma, 11'h00D)
        wait_v(chg, 1'b0, 450);
        bus(0, charger_pkg::REG0_ADDR, 32'h0000_0000);
        `CHK({r[5:4], r[2:0]}, 5'b11110)
        $display("test charge done");
    endtask
    task automatic t_topoff();
        do_reset(9'h180);
        wait_v(stat, 1'b1, 40);
        `CHK({chg, bsw, qsw}, 3'b011)
        // top-off enabled before termination
        bus(1, charger_pkg::REG7_ADDR, 32'h0000_000B);
        wait_v(chg, 1'b1, 40);
        `CHK(chg, 1'b1)
        // comparator trips once at the normal level, then the top-off level applies
        @(posedge clk_sys_i) sense.below_term <= 1'b1;
        @(posedge clk_sys_i) sense.below_term <= 1'b0;
        tick(4);
        `CHK({chg, stat}, 2'b11)
        `CHK(tgt.termination_current_ma, 9'h0C8)
        bus(0, charger_pkg::REG7_ADDR, 32'h0000_0000);
        `CHK(r[4], 1'b1)
        @(posedge clk_sys_i) sense.below_term <= 1'b1;
        wait_v(chg, 1'b0, 10);
        bus(0, charger_pkg::REG7_ADDR, 32'h0000_0000);
        `CHK({chg, stat, r[4]}, 3'b010)
        @(posedge clk_sys_i) {sense.below_term, sense.below_recharge} <= 2'b01;
        wait_v(load, 1'b1, 20);
        `CHK(load, 1'b1)
        wait_v(chg, 1'b1, 30);
        `CHK(chg, 1'b1)
        $display("test topoff done");
    endtask
    task automatic t_watchdog();
        do_reset(9'h180);
        wait_v(stat, 1'b1, 40);
        bus(1, charger_pkg::REG2_ADDR, 32'h0000_0014);
        tick(140);
        // host keeps the watchdog alive
        bus(1, charger_pkg::REG0_ADDR, 32'h0000_0080);
        tick(120);
        bus(0, charger_pkg::REG2_ADDR, 32'h0000_0000);
        `CHK(r, 32'h0000_0014)
        tick(100);
        bus(0, charger_pkg::REG2_ADDR, 32'h0000_0000);
        `CHK(r, 32'h0000_0008)
        wait_v(chg, 1'b1, 40);
        `CHK(chg, 1'b1)
        $display("test watchdog done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // main sequence and hang guard
    initial begin
        t_decode();
        t_charge();
        t_topoff();
        t_watchdog();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        close_out();
    end
endmodule // charger_cycle_supervisor_bench
